/* paof_pkg.sv */
// Constants shared by the port alternate-function override block.
// Assumes one 200 MHz clock domain and a synchronous active-high reset.
package paof_pkg;
   //==========================================================
   // Pin indexing
   localparam int PAOF_NUM_OVR = 10;
   localparam int PAOF_NUM_PC = 16;
   localparam int PAOF_IDX_B6 = 8;
   localparam int PAOF_IDX_B7 = 9;
   localparam int PAOF_PC_B6 = 14;
   localparam int PAOF_PC_B7 = 15;
   localparam int PAOF_PC_B0 = 8;
   localparam int PAOF_PC_B1 = 9;
   localparam int PAOF_SYNC_STAGES = 2;
   //==========================================================
   // Pull-up combination {dir, out, pud} that enables the pull-up
   localparam logic [2:0] PAOF_PULLUP_COMBO = 3'h2;
   localparam logic [15:0] PAOF_SYNC_RST = 16'h0000;
endpackage : paof_pkg

/* paof_override.sv */
// Override logic for port A pins 7..0 and port B pins 7 and 6.
// Assumes the port registers, peripherals and fuses share clk; pins are asynchronous.
//
// How it works
// (R1) Three-wire serial data output replaces port A pin 1 value; drives only if direction set.
// (R2) Port A pin 1 output bit still enables pull-up when input and set.
// (R3) Serial data input does not override; software makes that pin an input.
// (R4) Port A pins 7..4 have all output-side overrides at constant 0.
// (R5) Pins 7..4 input override: mask and group enable, or digital-disable; value is disable.
// (R6) Port A pin 3 output overrides 0; input override from mask and group, value 0.
// (R7) Pin 2 input override: mask/group, irq one, disable, or start-irq with position.
// (R8) Reset-disable fuse programmed makes port B pin 7 an ordinary I/O pin.
// (R9) Reset-disable fuse unprogrammed ties port B pin 7 to reset, not I/O.
// (R10) As reset pin, port B pin 7 direction, output and input read 0.
// (R11) Debug fuse with lock unprogrammed makes reset pin open-drain, pull-up on.
// (R12) Port A pin n is change source n; port B 7 and 6 are 15 and 14.
// (R13) Port B pins 1 and 0 are sources 9 and 8 of change group 1.
// (R14) Port B pin 6 supplies the timer 0 external count input.
// (R15) Port B pin 6 is the source of external interrupt 0.
// (R16) Without pull-up override, pull-up on only for combination 0b010, else override value.
// (R17) Direction override enable selects override value for driver, else direction bit.
// (R18) Value override with driver on selects override value, else output bit.
// (R19) Input-enable override sets the input buffer enable regardless of sleep state.
// (R20) Overrides are combinational per pin; peripherals get inputs after the buffer.
module paof_override
   import paof_pkg::*;
(
   input wire logic clk, // 200 MHz clock
   input wire logic srst, // Synchronous reset, active high
   input wire logic [7:0] porta_dir, // Port A direction bits
   input wire logic [7:0] porta_out, // Port A output bits
   input wire logic [7:0] porta_pin_i, // Port A pad levels
   output logic [7:0] porta_pin_o, // Port A pad drive value
   output logic [7:0] porta_pin_oe, // Port A driver enable
   output logic [7:0] porta_pullup, // Port A pull-up enable
   output logic [7:0] porta_in_en, // Port A input buffer enable
   output logic [7:0] porta_toggle, // Port A output bit toggle request
   input wire logic [1:0] portb_hi_dir, // Port B pins 7,6 direction bits
   input wire logic [1:0] portb_hi_out, // Port B pins 7,6 output bits
   input wire logic [1:0] portb_hi_pin_i, // Port B pins 7,6 pad levels
   output logic [1:0] portb_hi_pin_o, // Port B pins 7,6 drive value
   output logic [1:0] portb_hi_pin_oe, // Port B pins 7,6 driver enable
   output logic [1:0] portb_hi_pullup, // Port B pins 7,6 pull-up enable
   output logic [1:0] portb_hi_in_en, // Port B pins 7,6 input buffer enable
   input wire logic [5:0] portb_lo_pin_i, // Port B pins 5..0 pad levels
   input wire logic portb_pin2_dir, // Port B pin 2 direction bit
   input wire logic portb_pin2_out, // Port B pin 2 output bit
   input wire logic portb_pin0_dir, // Port B pin 0 direction bit
   input wire logic portb_pin0_out, // Port B pin 0 output bit
   input wire logic pullup_disable, // Global pull-up disable
   input wire logic sleep_state, // High while asleep
   input wire logic [15:0] pin_change_mask, // Pin-change masks by source
   input wire logic pin_change_group_en, // Pin-change group enable
   input wire logic [7:0] porta_analog_disable, // Port A digital-disable bits
   input wire logic [1:0] portb_hi_analog_disable, // Port B 7,6 digital-disable bits
   input wire logic serial_twowire_mode, // Serial two-wire mode
   input wire logic serial_threewire_mode, // Serial three-wire mode
   input wire logic serial_position_select, // Serial pins on port A
   input wire logic serial_clock_stretch, // Serial clock hold low
   input wire logic serial_clock_toggle, // Serial clock toggle request
   input wire logic serial_start_irq_en, // Serial start-detect irq enable
   input wire logic serial_data_out, // Serial data output bit
   input wire logic serial_sda_out, // Serial two-wire data drive
   input wire logic ext_irq_one_en, // External interrupt 1 enable
   input wire logic reset_pin_disable_fuse, // High when fuse programmed
   input wire logic single_wire_debug_fuse, // High when fuse programmed
   input wire logic lock_bits_clear, // High when lock bits unprogrammed
   input wire logic single_wire_debug_tx, // High pulls debug line low
   output logic portb_pin7_dir, // Pin 7 direction read-back
   output logic portb_pin7_out, // Pin 7 output read-back
   output logic portb_pin7_in, // Pin 7 input read-back
   output logic reset_pin_active, // External reset request
   output logic single_wire_debug_io, // Debug line receive level
   output logic [15:0] pin_change_in, // Pin-change sources
   output logic [1:0] pin_change_group1, // Group 1 sources 9,8
   output logic serial_data_in, // Serial data input
   output logic serial_shift_clock, // Serial clock input
   output logic ext_irq_one, // External interrupt 1 input
   output logic ext_irq_zero, // External interrupt 0 input
   output logic timer0_ext_count, // Timer 0 count input
   output logic timer0_capture_in // Timer 0 capture input
);
   //==========================================================
   // State
   typedef struct packed {
      logic [15:0] sync1;
      logic [15:0] sync2;
   } paof_state_s;

   paof_state_s state_reg;
   paof_state_s state_next;

   // Pads pass both stages before any logic reads them
   always_comb begin
      state_next = state_reg;
      state_next.sync1 = {portb_hi_pin_i, portb_lo_pin_i, porta_pin_i};
      state_next.sync2 = state_reg.sync1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= '{sync1: PAOF_SYNC_RST, sync2: PAOF_SYNC_RST};
      end else begin
         state_reg <= state_next;
      end
   end

   //==========================================================
   // Mode decode
   // Fuse inputs are high when programmed
   logic reset_mode;
   logic debug_mode;
   logic pc_grp;
   logic [7:0] pa_pc;
   assign reset_mode = ~reset_pin_disable_fuse; // R8 R9
   assign debug_mode = reset_mode & single_wire_debug_fuse & lock_bits_clear; // R11
   assign pc_grp = pin_change_group_en;
   assign pa_pc = pin_change_mask[7:0] & {8{pc_grp}};

   //==========================================================
   // Override signals, index 0..7 port A, 8 port B6, 9 port B7
   logic [9:0] pu_oe, pu_ov;
   logic [9:0] dd_oe, dd_ov;
   logic [9:0] pv_oe, pv_ov, pt_oe;
   logic [9:0] die_oe, die_ov;
   logic [9:0] dir_v, out_v;

   always_comb begin
      pu_oe = '0; // R4 R6
      pu_ov = '0;
      dd_oe = '0;
      dd_ov = '0;
      pv_oe = '0;
      pv_ov = '0;
      pt_oe = '0;
      die_oe = '0;
      die_ov = '0;
      die_oe[7:4] = pa_pc[7:4] | porta_analog_disable[7:4]; // R5
      die_ov[7:4] = porta_analog_disable[7:4]; // R5
      die_oe[3] = pa_pc[3]; // R6
      dd_oe[2] = serial_twowire_mode & serial_position_select;
      dd_ov[2] = (serial_clock_stretch | portb_pin2_out) & portb_pin2_dir & serial_position_select;
      pv_oe[2] = serial_twowire_mode & portb_pin2_dir;
      pt_oe[2] = serial_clock_toggle & serial_position_select;
      die_oe[2] = pa_pc[2] | ext_irq_one_en | porta_analog_disable[2]
         | (serial_start_irq_en & serial_position_select); // R7
      die_ov[2] = porta_analog_disable[2];
      pv_oe[1] = serial_threewire_mode & serial_position_select; // R1
      pv_ov[1] = serial_data_out & serial_position_select; // R1
      die_oe[1] = pa_pc[1] | porta_analog_disable[1];
      die_ov[1] = porta_analog_disable[1];
      dd_oe[0] = serial_twowire_mode & serial_position_select;
      dd_ov[0] = (serial_sda_out | portb_pin0_out) & portb_pin0_dir & serial_position_select;
      pv_oe[0] = serial_twowire_mode & portb_pin0_dir & serial_position_select;
      die_oe[0] = pa_pc[0] | porta_analog_disable[0] | (serial_start_irq_en & serial_position_select);
      die_ov[0] = porta_analog_disable[0];
      die_oe[PAOF_IDX_B6] = pin_change_mask[PAOF_PC_B6] & pc_grp
         | portb_hi_analog_disable[0];
      die_ov[PAOF_IDX_B6] = portb_hi_analog_disable[0];
      // Pin 7 as reset input or open-drain debug line
      pu_oe[PAOF_IDX_B7] = reset_mode; // R9 R11
      pu_ov[PAOF_IDX_B7] = 1'b1; // R11
      dd_oe[PAOF_IDX_B7] = reset_mode; // R9
      dd_ov[PAOF_IDX_B7] = debug_mode & single_wire_debug_tx; // R11
      pv_oe[PAOF_IDX_B7] = reset_mode; // R11
      pv_ov[PAOF_IDX_B7] = 1'b0; // R11
      die_oe[PAOF_IDX_B7] = reset_mode & ~debug_mode;
      die_ov[PAOF_IDX_B7] = 1'b1;
   end

   assign dir_v = {portb_hi_dir, porta_dir};
   assign out_v = {portb_hi_out, porta_out};

   //==========================================================
   // Per-pin resolve
   logic [9:0] pin_o, pin_oe, pin_pu, pin_ie;
   genvar gi;
   generate
      for (gi = 0; gi < PAOF_NUM_OVR; gi++) begin : g_pin // R20
         assign pin_oe[gi] = dd_oe[gi] ? dd_ov[gi] : dir_v[gi]; // R17 R1
         assign pin_o[gi] = pv_oe[gi] ? pv_ov[gi] : out_v[gi]; // R18
         assign pin_pu[gi] = pu_oe[gi] ? pu_ov[gi]
            : ({dir_v[gi], out_v[gi], pullup_disable} == PAOF_PULLUP_COMBO); // R16 R2
         // Override value high turns the buffer off
         assign pin_ie[gi] = die_oe[gi] ? ~die_ov[gi] : ~sleep_state; // R19
      end
   endgenerate

   assign porta_pin_o = pin_o[7:0];
   assign porta_pin_oe = pin_oe[7:0];
   assign porta_pullup = pin_pu[7:0];
   assign porta_in_en = pin_ie[7:0];
   assign porta_toggle = pt_oe[7:0];
   assign portb_hi_pin_o = pin_o[9:8];
   assign portb_hi_pin_oe = pin_oe[9:8];
   assign portb_hi_pullup = pin_pu[9:8];
   assign portb_hi_in_en = pin_ie[9:8];

   //==========================================================
   // Input routing
   // Gating after the synchroniser keeps raw pads out of logic
   logic [15:0] din;
   always_comb begin
      din = state_reg.sync2;
      din[7:0] = state_reg.sync2[7:0] & pin_ie[7:0];
      din[PAOF_PC_B6] = state_reg.sync2[PAOF_PC_B6] & pin_ie[PAOF_IDX_B6];
      din[PAOF_PC_B7] = state_reg.sync2[PAOF_PC_B7] & pin_ie[PAOF_IDX_B7];
   end

   assign pin_change_in = din; // R12
   assign pin_change_group1 = {din[PAOF_PC_B1], din[PAOF_PC_B0]}; // R13
   assign serial_data_in = din[0]; // R3
   assign serial_shift_clock = din[2]; // R7
   assign ext_irq_one = din[2]; // R7
   assign timer0_capture_in = din[4];
   assign timer0_ext_count = din[PAOF_PC_B6]; // R14
   assign ext_irq_zero = din[PAOF_PC_B6]; // R15
   assign reset_pin_active = reset_mode & ~debug_mode & ~state_reg.sync2[PAOF_PC_B7]; // R9
   assign single_wire_debug_io = debug_mode & state_reg.sync2[PAOF_PC_B7]; // R11
   assign portb_pin7_dir = portb_hi_dir[1] & ~reset_mode; // R10
   assign portb_pin7_out = portb_hi_out[1] & ~reset_mode; // R10
   assign portb_pin7_in = din[PAOF_PC_B7] & ~reset_mode; // R10
endmodule : paof_override

/* paof_override_asserts.sv */
// Checker for paof_override, bound to every instance.
// Assumes one clock domain and a synchronous active-high reset.
module paof_override_asserts (
   input logic clk, // Clock
   input logic srst, // Reset
   input logic [7:0] porta_dir, // Directions
   input logic [7:0] porta_out, // Output bits
   input logic [7:0] porta_pin_i, // Pads
   input logic [7:0] porta_pin_o, // Drive values
   input logic [7:0] porta_pin_oe, // Drivers on
   input logic [7:0] porta_pullup, // Pull-ups
   input logic [7:0] porta_in_en, // Input enables
   input logic [7:0] porta_toggle, // Toggles
   input logic pullup_disable, // Pull-up off
   input logic serial_threewire_mode, // Three-wire
   input logic serial_position_select, // Serial on A
   input logic serial_data_out, // Serial data
   input logic reset_pin_disable_fuse, // Fuse
   input logic portb_pin7_dir, // Read-back
   input logic portb_pin7_out, // Read-back
   input logic portb_pin7_in, // Read-back
   input logic [15:0] pin_change_in // Sources
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   // Two clean edges fill the synchroniser
   sequence out_of_reset_s;
      !srst ##1 !srst;
   endsequence
   //==========================================================
   // Overrides and routing
   fixed_hi_a: assert property (porta_pin_oe[7:3] == porta_dir[7:3]
      && porta_pin_o[7:3] == porta_out[7:3] && porta_toggle[7:3] == 5'h00) else $error("fixed pins");
   pullup_hi_a: assert property (porta_pullup[7:3] ==
      (~porta_dir[7:3] & porta_out[7:3] & {5{!pullup_disable}})) else $error("pull-up combo");
   serial_out_a: assert property (serial_threewire_mode && serial_position_select
      |-> porta_pin_o[1] == serial_data_out) else $error("serial data not on pin");
   pa1_driver_a: assert property (porta_pin_oe[1] == porta_dir[1]) else $error("pin 1 driver");
   pa1_value_a: assert property (!(serial_threewire_mode && serial_position_select)
      |-> porta_pin_o[1] == porta_out[1]) else $error("pin 1 value");
   pa1_pullup_a: assert property (!porta_dir[1] && !pullup_disable
      |-> porta_pullup[1] == porta_out[1]) else $error("pin 1 pull-up");
   reset_pin_rd_a: assert property (!reset_pin_disable_fuse
      |-> !(portb_pin7_dir || portb_pin7_out || portb_pin7_in)) else $error("reset pin reads");
   change_src_a: assert property (out_of_reset_s
      |=> pin_change_in[7:0] == ($past(porta_pin_i, 2) & porta_in_en)) else $error("change source");
endmodule : paof_override_asserts
bind paof_override paof_override_asserts chk_i (.*);

/* paof_pads.sv */
// Far-side pin model: outside devices drive every pin the block leaves free.
// Assumes a pin driven by the block overrides the outside level.
module paof_pads #(parameter int W = 8) (
   input logic [W-1:0] drv_o, // Block value
   input logic [W-1:0] drv_oe, // Block drives
   input logic [W-1:0] ext, // Outside level
   output logic [W-1:0] pad // Pin level
);
   timeunit 1ns;
   timeprecision 1ps;
   assign pad = (drv_oe & drv_o) | (~drv_oe & ext);
endmodule : paof_pads

/* tb.sv */
// Self-checking bench for paof_override with pin models on port A and on port B pins 7 and 6.
// Assumes the package, design, checker and pin model are compiled first.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, srst = 1, portb_pin2_dir = 0, portb_pin2_out = 0, portb_pin0_dir = 0;
   logic portb_pin0_out = 0, pullup_disable = 0, sleep_state = 0, pin_change_group_en = 0;
   logic serial_twowire_mode = 0, serial_threewire_mode = 0, serial_position_select = 0;
   logic serial_clock_stretch = 0, serial_clock_toggle = 0, serial_start_irq_en = 0;
   logic serial_data_out = 0, serial_sda_out = 0, ext_irq_one_en = 0, lock_bits_clear = 0;
   logic reset_pin_disable_fuse = 0, single_wire_debug_fuse = 0, single_wire_debug_tx = 0;
   logic [7:0] porta_dir = '0, porta_out = '0, porta_analog_disable = '0, ext_a = '0;
   logic [1:0] portb_hi_dir = '0, portb_hi_out = '0, portb_hi_analog_disable = '0, ext_b = '0;
   logic [5:0] portb_lo_pin_i = '0;
   logic [15:0] pin_change_mask = '1;
   logic portb_pin7_dir, portb_pin7_out, portb_pin7_in, reset_pin_active, single_wire_debug_io;
   logic serial_data_in, serial_shift_clock, ext_irq_one, ext_irq_zero, timer0_ext_count;
   logic timer0_capture_in;
   logic [7:0] porta_pin_i, porta_pin_o, porta_pin_oe, porta_pullup, porta_in_en, porta_toggle;
   logic [1:0] portb_hi_pin_i, portb_hi_pin_o, portb_hi_pin_oe, portb_hi_pullup, portb_hi_in_en;
   logic [1:0] pin_change_group1;
   logic [15:0] pin_change_in;
   int n_fail, checks_done, cycles;
   paof_pads #(.W(8)) pads_a (.drv_o(porta_pin_o), .drv_oe(porta_pin_oe), .ext(ext_a),
      .pad(porta_pin_i));
   paof_pads #(.W(2)) pads_b (.drv_o(portb_hi_pin_o), .drv_oe(portb_hi_pin_oe), .ext(ext_b),
      .pad(portb_hi_pin_i));
   paof_override uut (.*);
   initial begin
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 500) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   //==========================================================
   // Scenarios
   task automatic t_hi();
      {porta_dir, porta_out} = {8'hA5, 8'h3C};
      for (int k = 0; k < 8; k++) begin
         {pin_change_group_en, porta_analog_disable[7], sleep_state} = k[2:0];
         step(1);
         chk(porta_in_en[7:3], {!k[1] && (k[2] || !k[0]), {4{k[2] || !k[0]}}});
      end
      $display("t_hi done");
   endtask : t_hi
   task automatic t_pa1();
      {serial_threewire_mode, serial_position_select, serial_data_out} = 3'h7;
      {porta_dir[1], porta_out[1]} = 2'h2;
      step(1);
      chk(porta_pin_i[1], 1'b1);
      {porta_dir[1], porta_out[1], serial_data_out} = 3'h2;
      step(1);
      chk({porta_pin_oe[1], porta_pullup[1], porta_pin_i[1]}, {2'h1, ext_a[1]});
      {pullup_disable, serial_threewire_mode} = 2'h2;
      step(1);
      chk(porta_pullup[1], 1'b0);
      $display("t_pa1 done");
   endtask : t_pa1
   task automatic t_pa2();
      {sleep_state, pullup_disable} = 2'h2;
      for (int k = 0; k < 4; k++) begin
         {pin_change_group_en, ext_irq_one_en, serial_start_irq_en} = 3'(k == 3 ? 0 : 4 >> k);
         step(1);
         chk(porta_in_en[2], k != 3);
      end
      $display("t_pa2 done");
   endtask : t_pa2
   task automatic t_twowire();
      {serial_twowire_mode, portb_pin0_dir, portb_pin2_dir, porta_out} = {3'h7, 8'hFF};
      for (int k = 0; k < 4; k++) begin
         {serial_sda_out, portb_pin0_out, serial_clock_stretch, portb_pin2_out} = {2{k[1:0]}};
         serial_clock_toggle = k[0];
         step(1);
         chk(porta_pin_oe[2:0], {k != 0, porta_dir[1], k != 0});
         chk({porta_pin_o[2], porta_pin_o[0]}, 2'h0);
         chk(porta_toggle, {5'h00, k[0], 2'h0});
      end
      serial_twowire_mode = 1'b0;
      $display("t_twowire done");
   endtask : t_twowire
   task automatic t_route();
      {porta_dir, porta_analog_disable, sleep_state, pin_change_group_en} = '0;
      {reset_pin_disable_fuse, ext_b, ext_a, portb_lo_pin_i} = {3'h6, 8'h5B, 6'h25};
      step(3);
      chk(pin_change_in, 16'hA55B);
      chk({pin_change_group1, serial_data_in, ext_irq_zero, timer0_ext_count}, 5'h0C);
      chk({serial_shift_clock, ext_irq_one, timer0_capture_in}, 3'h1);
      ext_b = 2'h1;
      step(3);
      chk({pin_change_in[15:14], ext_irq_zero, timer0_ext_count}, 4'h7);
      $display("t_route done");
   endtask : t_route
   task automatic t_pb7();
      {portb_hi_dir, portb_hi_out, ext_b} = 6'h28;
      step(3);
      chk({portb_pin7_dir, portb_pin7_out, reset_pin_active}, 3'h6);
      {reset_pin_disable_fuse, ext_b} = 3'h0;
      step(3);
      chk({portb_pin7_dir, portb_pin7_out, portb_pin7_in, reset_pin_active}, 4'h1);
      ext_b = 2'h2;
      step(3);
      chk(reset_pin_active, 1'b0);
      {single_wire_debug_fuse, lock_bits_clear, single_wire_debug_tx} = 3'h7;
      step(1);
      chk({portb_hi_pin_oe[1], portb_hi_pullup[1], portb_hi_pin_i[1]}, 3'h6);
      lock_bits_clear = 1'b0;
      step(1);
      chk(portb_hi_pin_oe[1], 1'b0);
      {lock_bits_clear, single_wire_debug_tx} = 2'h2;
      step(3);
      chk({single_wire_debug_io, reset_pin_active, portb_pin7_in}, 3'h4);
      $display("t_pb7 done");
   endtask : t_pb7
   initial begin
      step(20);
      srst = 1'b0;
      step(2);
      t_hi();
      t_pa1();
      t_pa2();
      t_twowire();
      t_route();
      t_pb7();
      end_of_test();
   end
endmodule : tb
